// >>> common/ivrel_pkg.sv
// Package of constants for the interrupt vector relocation block.
`default_nettype none
package ivrel_pkg;
  // ==========================================================================
  // Control register layout
  // ==========================================================================
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_SELECT = 1;
  localparam int BIT_RC_CLK = 2;
  localparam int BIT_RST_DIS = 3;
  localparam int BIT_PULLUP_DIS = 4;
  localparam logic [7:0] CTRL_RW_MASK = 8'h1F;
  // ==========================================================================
  // Addresses and timing
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam logic [11:0] APP_RESET_ADDR = 12'h000;
  localparam logic [11:0] VECTOR_OFFSET = 12'h001;
  localparam logic [11:0] BOOT_START_2K = 12'hC00;
  localparam logic [11:0] BOOT_START_1K = 12'hE00;
  localparam logic [11:0] BOOT_START_512 = 12'hF00;
  localparam logic [11:0] BOOT_START_256 = 12'hF80;
  localparam logic [1:0] BOOT_SIZE_2K = 2'h0;
  localparam logic [1:0] BOOT_SIZE_1K = 2'h1;
  localparam logic [1:0] BOOT_SIZE_512 = 2'h2;
  localparam logic FUSE_UNPROGRAMMED = 1'b1;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
endpackage
`default_nettype wire

// >>> rtl/ivrel_addr_map.sv
// Boot section start and vector table address decoding.
`timescale 1ns/1ps
`default_nettype none
module ivrel_addr_map
(
  input wire logic [1:0] boot_size_fuses_in, // Boot size fuse pair.
  input wire logic boot_reset_fuse_in, // One means unprogrammed.
  input wire logic select_in, // Vector table select.
  output logic [11:0] boot_start_out, // Boot section word address.
  output logic [11:0] reset_addr_out, // Reset fetch address.
  output logic [11:0] vector_base_out // Vector table start.
);
  // ==========================================================================
  // Decoding
  // ==========================================================================
  // Boot start from the size fuses; the 2K setting lands at its fixed start.
  always_comb
  begin
    unique case (boot_size_fuses_in)
      ivrel_pkg::BOOT_SIZE_2K: boot_start_out = ivrel_pkg::BOOT_START_2K;
      ivrel_pkg::BOOT_SIZE_1K: boot_start_out = ivrel_pkg::BOOT_START_1K;
      ivrel_pkg::BOOT_SIZE_512: boot_start_out = ivrel_pkg::BOOT_START_512;
      default: boot_start_out = ivrel_pkg::BOOT_START_256;
    endcase
  end

  // Reset from zero unless the fuse is programmed (zero).
  assign reset_addr_out = (boot_reset_fuse_in == ivrel_pkg::FUSE_UNPROGRAMMED) ?
    ivrel_pkg::APP_RESET_ADDR : boot_start_out;

  // Vector table one word past zero or past the boot start.
  assign vector_base_out = select_in ? (boot_start_out + ivrel_pkg::VECTOR_OFFSET)
    : ivrel_pkg::VECTOR_OFFSET;
endmodule
`default_nettype wire

// >>> rtl/ivrel_ctrl.sv
// Control register, timed vector select change and interrupt blocking.
`timescale 1ns/1ps
`default_nettype none
module ivrel_ctrl
(
  input wire logic clk_in, // System clock, 200 MHz.
  input wire logic resetn_in, // Asynchronous reset, active low.
  input wire logic ctrl_wr_in, // Register write strobe from the core.
  input wire logic [7:0] ctrl_wdata_in, // Register write data.
  output logic [7:0] ctrl_rdata_out, // Register read data.
  input wire logic instr_done_in, // Core finished an instruction this cycle.
  input wire logic [11:0] pc_in, // Current program word address.
  input wire logic [1:0] boot_size_fuses_in, // Boot size fuse pair.
  input wire logic boot_reset_fuse_in, // Boot reset fuse.
  input wire logic app_side_boot_lock_in, // Zero means programmed.
  input wire logic boot_side_boot_lock_in, // Zero means programmed.
  input wire logic global_int_enable_in, // Core status register enable bit.
  output logic int_allow_out, // Interrupts may be taken.
  output logic [11:0] reset_addr_out, // Reset fetch address.
  output logic [11:0] vector_base_out, // Vector table start address.
  output logic pullup_global_disable_out, // Kills every port pull-up.
  output logic reset_pin_disable_out, // Reset pin disable.
  output logic rc_clock_freq_select_out // RC clock select.
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [1:0] {IVREL_IDLE, IVREL_OPEN, IVREL_TRAIL} ivrel_state_t;
  ivrel_state_t state_reg;
  logic [7:0] ctrl_reg;
  logic [2:0] unlock_cnt_reg;
  logic [11:0] boot_start;
  logic unlock_wr;
  logic select_wr;
  logic seq_mask;
  logic in_boot;
  logic lock_block;

  // Unlock is a write with the unlock bit one; any write with it zero inside the window changes select.
  assign unlock_wr = ctrl_wr_in && ctrl_wdata_in[ivrel_pkg::BIT_UNLOCK];
  assign select_wr = ctrl_wr_in && !ctrl_wdata_in[ivrel_pkg::BIT_UNLOCK] && ctrl_reg[ivrel_pkg::BIT_UNLOCK];

  // ==========================================================================
  // Control register
  // ==========================================================================
  // Plain bits store directly; select only moves inside the unlock window.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ctrl_reg <= ivrel_pkg::CTRL_RESET;
    else if (ctrl_wr_in)
    begin
      ctrl_reg[7:5] <= 3'h0;
      ctrl_reg[ivrel_pkg::BIT_PULLUP_DIS] <= ctrl_wdata_in[ivrel_pkg::BIT_PULLUP_DIS];
      ctrl_reg[ivrel_pkg::BIT_RST_DIS] <= ctrl_wdata_in[ivrel_pkg::BIT_RST_DIS];
      ctrl_reg[ivrel_pkg::BIT_RC_CLK] <= ctrl_wdata_in[ivrel_pkg::BIT_RC_CLK];
      if (select_wr)
        ctrl_reg[ivrel_pkg::BIT_SELECT] <= ctrl_wdata_in[ivrel_pkg::BIT_SELECT];
      // Rewriting unlock while open restarts the window, a harmless reading.
      ctrl_reg[ivrel_pkg::BIT_UNLOCK] <= unlock_wr;
    end
    else if (ctrl_reg[ivrel_pkg::BIT_UNLOCK] && unlock_cnt_reg == 3'h1)
      ctrl_reg[ivrel_pkg::BIT_UNLOCK] <= 1'b0;
  end

  // Counts down the four-cycle unlock window.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      unlock_cnt_reg <= 3'h0;
    else if (unlock_wr)
      unlock_cnt_reg <= ivrel_pkg::UNLOCK_CYCLES;
    else if (select_wr)
      unlock_cnt_reg <= 3'h0;
    else if (unlock_cnt_reg != 3'h0)
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
  end

  // ==========================================================================
  // Sequence mask
  // ==========================================================================
  // After the select write the mask trails until the next instruction completes.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_reg <= IVREL_IDLE;
    else
    begin
      unique case (state_reg)
        IVREL_IDLE:
          if (unlock_wr)
            state_reg <= IVREL_OPEN;
        IVREL_OPEN:
          if (select_wr)
            state_reg <= IVREL_TRAIL;
          else if (!unlock_wr && unlock_cnt_reg == 3'h1)
            state_reg <= IVREL_IDLE;
        IVREL_TRAIL:
          if (unlock_wr)
            state_reg <= IVREL_OPEN;
          else if (instr_done_in)
            state_reg <= IVREL_IDLE;
      endcase
    end
  end

  // Mask is combinational so it bites in the very cycle of the unlock write.
  assign seq_mask = unlock_wr || (state_reg != IVREL_IDLE);

  // ==========================================================================
  // Lock-bit blocking and outputs
  // ==========================================================================
  assign in_boot = (pc_in >= boot_start);
  assign lock_block = (ctrl_reg[ivrel_pkg::BIT_SELECT] && !in_boot && !app_side_boot_lock_in)
    || (!ctrl_reg[ivrel_pkg::BIT_SELECT] && in_boot && !boot_side_boot_lock_in);

  // The global enable is only read here, never written, so software state survives.
  assign int_allow_out = global_int_enable_in && !seq_mask && !lock_block;

  assign ctrl_rdata_out = ctrl_reg & ivrel_pkg::CTRL_RW_MASK;
  assign pullup_global_disable_out = ctrl_reg[ivrel_pkg::BIT_PULLUP_DIS];
  assign reset_pin_disable_out = ctrl_reg[ivrel_pkg::BIT_RST_DIS];
  assign rc_clock_freq_select_out = ctrl_reg[ivrel_pkg::BIT_RC_CLK];

  ivrel_addr_map u_addr_map
  (
    .boot_size_fuses_in(boot_size_fuses_in),
    .boot_reset_fuse_in(boot_reset_fuse_in),
    .select_in(ctrl_reg[ivrel_pkg::BIT_SELECT]),
    .boot_start_out(boot_start),
    .reset_addr_out(reset_addr_out),
    .vector_base_out(vector_base_out)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_unlock_masks;
    @(posedge clk_in) disable iff (!resetn_in)
    unlock_wr |-> !int_allow_out;
  endproperty
  a_unlock_masks: assert property (p_unlock_masks) else $error("Unlock write did not mask interrupts.");

  property p_unlock_timeout;
    @(posedge clk_in) disable iff (!resetn_in)
    (unlock_wr ##1 (!ctrl_wr_in)[*4]) |=> !ctrl_reg[ivrel_pkg::BIT_UNLOCK];
  endproperty
  a_unlock_timeout: assert property (p_unlock_timeout) else $error("Unlock bit outlived four cycles.");

  property p_mask_window;
    @(posedge clk_in) disable iff (!resetn_in)
    (unlock_wr ##1 (!ctrl_wr_in)[*4]) |-> seq_mask ##1 (!seq_mask || unlock_wr);
  endproperty
  a_mask_window: assert property (p_mask_window) else $error("Mask window not four cycles.");

  property p_locked_select;
    @(posedge clk_in) disable iff (!resetn_in)
    (ctrl_wr_in && !ctrl_reg[ivrel_pkg::BIT_UNLOCK]) |=> $stable(ctrl_reg[ivrel_pkg::BIT_SELECT]);
  endproperty
  a_locked_select: assert property (p_locked_select) else $error("Select changed without unlock.");

  property p_select_clears_unlock;
    @(posedge clk_in) disable iff (!resetn_in)
    select_wr |=> !ctrl_reg[ivrel_pkg::BIT_UNLOCK]
      && (ctrl_reg[ivrel_pkg::BIT_SELECT] == $past(ctrl_wdata_in[ivrel_pkg::BIT_SELECT]));
  endproperty
  a_select_clears_unlock: assert property (p_select_clears_unlock) else $error("Select write mishandled.");

  property p_trail_mask;
    @(posedge clk_in) disable iff (!resetn_in)
    select_wr |=> !int_allow_out;
  endproperty
  a_trail_mask: assert property (p_trail_mask) else $error("Mask dropped right after select write.");

  property p_vector_base;
    @(posedge clk_in) disable iff (!resetn_in)
    !ctrl_reg[ivrel_pkg::BIT_SELECT] |-> vector_base_out == ivrel_pkg::VECTOR_OFFSET;
  endproperty
  a_vector_base: assert property (p_vector_base) else $error("Vector base not at flash start.");

  property p_boot_vectors;
    @(posedge clk_in) disable iff (!resetn_in)
    (ctrl_reg[ivrel_pkg::BIT_SELECT] && boot_size_fuses_in == ivrel_pkg::BOOT_SIZE_2K) |-> vector_base_out == 12'hC01;
  endproperty
  a_boot_vectors: assert property (p_boot_vectors) else $error("Boot vectors misplaced.");

  property p_upper_zero;
    @(posedge clk_in) disable iff (!resetn_in)
    ctrl_rdata_out[7:5] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Reserved bits read nonzero.");

  property p_lock_block;
    @(posedge clk_in) disable iff (!resetn_in)
    (ctrl_reg[ivrel_pkg::BIT_SELECT] && !in_boot && !app_side_boot_lock_in) |-> !int_allow_out;
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("Application lock did not block.");

  property p_boot_lock_block;
    @(posedge clk_in) disable iff (!resetn_in)
    (!ctrl_reg[ivrel_pkg::BIT_SELECT] && in_boot && !boot_side_boot_lock_in) |-> !int_allow_out;
  endproperty
  a_boot_lock_block: assert property (p_boot_lock_block) else $error("Boot lock did not block.");
endmodule
`default_nettype wire

// >>> bench/ivrel_core_model.sv
// Core model that completes one instruction every third cycle.
`timescale 1ns/1ps
`default_nettype none
module ivrel_core_model
(
  input wire logic clk_in, // System clock.
  input wire logic resetn_in, // Reset, active low.
  output logic instr_done_out // Instruction completes this cycle.
);
  logic [1:0] phase_reg;
  // Multi-cycle instructions keep the trailing mask open for a few cycles.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      phase_reg <= 2'h0;
      instr_done_out <= 1'b0;
    end
    else
    begin
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      instr_done_out <= (phase_reg == 2'h2);
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the vector relocation control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in, resetn_in, wr, done, gie, app_lock, boot_lock, rst_fuse, allow, pullup_global_disable, rsd, rcs;
  logic [7:0] wdata, rdata, d;
  logic [11:0] pc, rst_addr, vbase;
  logic [1:0] size;
  integer seed, bad_count, samples_checked, i, n;
  // ==========================================================================
  // Design, core model and clock
  // ==========================================================================
  ivrel_ctrl uut (.clk_in(clk_in), .resetn_in(resetn_in), .ctrl_wr_in(wr), .ctrl_wdata_in(wdata),
    .ctrl_rdata_out(rdata), .instr_done_in(done), .pc_in(pc), .boot_size_fuses_in(size),
    .boot_reset_fuse_in(rst_fuse), .app_side_boot_lock_in(app_lock), .boot_side_boot_lock_in(boot_lock),
    .global_int_enable_in(gie), .int_allow_out(allow), .reset_addr_out(rst_addr), .vector_base_out(vbase),
    .pullup_global_disable_out(pullup_global_disable), .reset_pin_disable_out(rsd), .rc_clock_freq_select_out(rcs));
  ivrel_core_model core (.clk_in(clk_in), .resetn_in(resetn_in), .instr_done_out(done));
  // The clock toggles every half period of 2.5 ns.
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Four-state compare, so an unknown never counts as a match.
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Boot section start for each size fuse code.
  function automatic logic [11:0] start(input logic [1:0] s);
    case (s)
      ivrel_pkg::BOOT_SIZE_2K: return ivrel_pkg::BOOT_START_2K;
      ivrel_pkg::BOOT_SIZE_1K: return ivrel_pkg::BOOT_START_1K;
      ivrel_pkg::BOOT_SIZE_512: return ivrel_pkg::BOOT_START_512;
      default: return 12'hF80;
    endcase
  endfunction
  // One register write; the strobe stands for exactly one cycle.
  task automatic put(input logic [7:0] v);
    @(posedge clk_in);
    wr <= 1'b1;
    wdata <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {resetn_in, wr, gie, rst_fuse, app_lock, boot_lock} = 6'h0F;
    resetn_in = 1'b0;
    {wdata, pc, size} = 22'h0;
    seed = 9;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1 check("reset value", rdata, 8'h00);
    check("vector base", vbase, ivrel_pkg::VECTOR_OFFSET);
    // Reset address for every size and fuse state.
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_in);
      size <= i[1:0];
      rst_fuse <= i[2];
      #1 check("reset addr", rst_addr, i[2] ? 12'h000 : start(i[1:0]));
    end
    // Random writes without unlock: select is refused, other bits land.
    for (i = 0; i < 6; i++)
    begin
      d = $random(seed) & 8'hFE;
      gie <= $random(seed);
      pc <= $random(seed);
      put(d);
      #1 check("ctrl", rdata, d & 8'h1C);
      check("outs", {pullup_global_disable, rsd, rcs}, d[4:2]);
      check("allow idle", allow, gie);
    end
    gie <= 1'b1;
    // Unlock with no select write: mask lasts four cycles.
    @(posedge clk_in);
    wr <= 1'b1;
    wdata <= 8'h01;
    #1 check("allow c0", allow, 1'b0);
    @(posedge clk_in);
    wr <= 1'b0;
    for (i = 1; i <= 5; i++)
    begin
      #1 check("unlock bit", rdata[0], i < 5);
      check("allow trail", allow, i == 5);
      @(posedge clk_in);
    end
    // Unlock then select write in the next cycle, random boot size.
    size <= $random(seed);
    wr <= 1'b1;
    wdata <= 8'h01;
    @(posedge clk_in);
    wdata <= 8'h02;
    @(posedge clk_in);
    wr <= 1'b0;
    #1 check("select set", rdata, 8'h02);
    check("boot vectors", vbase, start(size) + 12'h001);
    check("allow held", allow, 1'b0);
    n = 0;
    while (allow !== 1'b1 && n < 8)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    check("mask release", n < 8, 1'b1);
    // Boot vectors with the application lock programmed.
    @(posedge clk_in);
    app_lock <= 1'b0;
    pc <= start(size) - 12'h001;
    #1 check("app blocked", allow, 1'b0);
    @(posedge clk_in);
    pc <= start(size);
    #1 check("boot free", allow, 1'b1);
    // Mid-run reset: the set select bit must fall back to zero at once.
    resetn_in <= 1'b0;
    @(posedge clk_in);
    resetn_in <= 1'b1;
    #1 check("mid reset", rdata, 8'h00);
    check("mid reset vectors", vbase, ivrel_pkg::VECTOR_OFFSET);
    app_lock <= 1'b1;
    put(8'h01);
    put(8'h00);
    // Let the trailing mask end, so the lock checks below see the lock alone.
    repeat (3) @(posedge clk_in);
    #1 check("vectors back", vbase, 12'h001);
    @(posedge clk_in);
    boot_lock <= 1'b0;
    #1 check("boot blocked", allow, 1'b0);
    @(posedge clk_in);
    pc <= 12'h000;
    #1 check("app free", allow, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
